/* rtl/pdmc_defines.vh */
// Functional notes
// - eight modes: full-speed active plus seven low-power
// - medium active runs on oscillator over 16..128
// - subactive runs on watch clock over 2/4/8
// - sleep stops cpu, peripherals keep system clock
// - subsleep keeps timers, serial, counter, display
// - watch keeps timekeeping, timer two, counter, display
// - standby stops cpu and every peripheral clock
// - each peripheral can be halted on its own
// - standby select picks sleep or standby target
// - wait field sets states waited on wake
// - off-recommendation settings may resume early
// - watch exit clock bit picks system or subclock
// - bit two reads one, writes ignored
// - wait field encodes the listed state counts
// - medium divider field selects 16/32/64/128
`ifndef PDMC_DEFINES_VH
`define PDMC_DEFINES_VH
// register byte offsets
`define PDMC_ADDR_CTRL_ONE 12'h000
`define PDMC_ADDR_HALT 12'h004
`define PDMC_ADDR_CFG 12'h008
`define PDMC_ADDR_STATUS 12'h00c
// control one field positions and reset
`define PDMC_BIT_DEEP 7
`define PDMC_WAIT_HI 6
`define PDMC_WAIT_LO 4
`define PDMC_BIT_WEXIT 3
`define PDMC_BIT_RSVD 2
`define PDMC_DIV_HI 1
`define PDMC_DIV_LO 0
`define PDMC_WAIT_RST 3'h0
`define PDMC_DIV_RST 2'h3
// config field positions
`define PDMC_CFG_MED 0
`define PDMC_CFG_WATCH 1
`define PDMC_CFG_SUB_HI 3
`define PDMC_CFG_SUB_LO 2
// mode codes
`define PDMC_M_ACT_HI 4'h0
`define PDMC_M_ACT_MED 4'h1
`define PDMC_M_SUBACT 4'h2
`define PDMC_M_SLP_HI 4'h3
`define PDMC_M_SLP_MED 4'h4
`define PDMC_M_SUBSLP 4'h5
`define PDMC_M_WATCH 4'h6
`define PDMC_M_STANDBY 4'h7
`define PDMC_M_WAKE 4'h8
// peripheral masks: 0 timer a,1 timer f,2 serial,3 counter,4 display
`define PDMC_MASK_SUBSLP 8'h1f
`define PDMC_MASK_WATCH 8'h1b
// wait field encodings
`define PDMC_WS_8192 3'h0
`define PDMC_WS_16384 3'h1
`define PDMC_WS_V2 3'h2
`define PDMC_WS_V3 3'h3
`define PDMC_WS_V4 3'h4
`define PDMC_WS_EXT 3'h5
`define PDMC_WS_8 3'h6
`define PDMC_WS_16 3'h7
// wait lengths in states
`define PDMC_ST_2 18'd2
`define PDMC_ST_8 18'd8
`define PDMC_ST_16 18'd16
`define PDMC_ST_1024 18'd1024
`define PDMC_ST_2048 18'd2048
`define PDMC_ST_4096 18'd4096
`define PDMC_ST_8192 18'd8192
`define PDMC_ST_16384 18'd16384
`define PDMC_ST_32768 18'd32768
`define PDMC_ST_65536 18'd65536
`define PDMC_ST_131072 18'd131072
// divider masks
`define PDMC_PM_16 7'h0f
`define PDMC_PM_32 7'h1f
`define PDMC_PM_64 7'h3f
`define PDMC_PM_128 7'h7f
`define PDMC_SM_2 3'h1
`define PDMC_SM_4 3'h3
`define PDMC_SM_8 3'h7
`endif

/* rtl/pdmc_top.v */
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_defines.vh"
module pdmc_top #(
   parameter NMOD = 8,
   parameter OSC_VARIANT = 0,
   parameter [17:0] WAIT_1024 = `PDMC_ST_1024,
   parameter [17:0] WAIT_2048 = `PDMC_ST_2048,
   parameter [17:0] WAIT_4096 = `PDMC_ST_4096,
   parameter [17:0] WAIT_8192 = `PDMC_ST_8192,
   parameter [17:0] WAIT_16384 = `PDMC_ST_16384,
   parameter [17:0] WAIT_32768 = `PDMC_ST_32768,
   parameter [17:0] WAIT_65536 = `PDMC_ST_65536,
   parameter [17:0] WAIT_131072 = `PDMC_ST_131072
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire sleep_req,
   input wire wake_irq,
   input wire watch_tick,
   output reg [3:0] mode_code,
   output reg cpu_run,
   output reg cpu_tick,
   output reg osc_run,
   output reg [NMOD-1:0] periph_tick
);

   //**********************************************
   // register state
   //**********************************************
   reg deep_standby_select, watch_exit_clock_select;
   reg medium_speed_sel, watch_select;
   reg [2:0] wake_wait_select;
   reg [1:0] medium_divider_select;
   reg [NMOD-1:0] module_clock_halt;
   reg [1:0] sub_divider_select;
   reg [3:0] mode;
   reg [17:0] wait_cnt;
   reg [6:0] presc;
   reg [2:0] sub_cnt;

   wire wr_en, setup, sys_tick, sub_tick;
   wire [7:0] ctrl_one_rd;
   reg [3:0] next_mode;
   reg [17:0] next_wait, wait_len;
   reg [6:0] pmask;
   reg [2:0] smask;
   reg [31:0] next_rdata;
   reg next_err, next_cpu_tick, next_cpu_run, mode_on_sub;
   reg [NMOD-1:0] mode_mask;

   //**********************************************
   // apb slave
   //**********************************************
   // write lands only at the completing access edge
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready & pwrite;
   assign ctrl_one_rd = {deep_standby_select, wake_wait_select,
      watch_exit_clock_select, 1'b1, medium_divider_select};

   // read data captured at setup so prdata is a flop
   always @* begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      case (paddr)
         `PDMC_ADDR_CTRL_ONE: next_rdata[7:0] = ctrl_one_rd;
         `PDMC_ADDR_HALT: next_rdata[NMOD-1:0] = module_clock_halt;
         `PDMC_ADDR_CFG: next_rdata[3:0] = {sub_divider_select,
            watch_select, medium_speed_sel};
         `PDMC_ADDR_STATUS: next_rdata[4:0] = {(mode == `PDMC_M_WAKE),
            mode};
         default: next_err = 1'b1;
      endcase
   end

   // one access cycle per transfer, ready raised from setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & next_err;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
         end
      end
   end

   // register writes; bit two has no storage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deep_standby_select <= 1'b0;
         wake_wait_select <= `PDMC_WAIT_RST;
         watch_exit_clock_select <= 1'b0;
         medium_divider_select <= `PDMC_DIV_RST;
         module_clock_halt <= {NMOD{1'b0}};
         medium_speed_sel <= 1'b0;
         watch_select <= 1'b0;
         sub_divider_select <= 2'h0;
      end else if (wr_en) begin
         if (paddr == `PDMC_ADDR_CTRL_ONE) begin
            deep_standby_select <= pwdata[`PDMC_BIT_DEEP];
            wake_wait_select <= pwdata[`PDMC_WAIT_HI:`PDMC_WAIT_LO];
            watch_exit_clock_select <= pwdata[`PDMC_BIT_WEXIT];
            medium_divider_select <= pwdata[`PDMC_DIV_HI:`PDMC_DIV_LO];
         end
         if (paddr == `PDMC_ADDR_HALT) begin
            module_clock_halt <= pwdata[NMOD-1:0];
         end
         if (paddr == `PDMC_ADDR_CFG) begin
            medium_speed_sel <= pwdata[`PDMC_CFG_MED];
            watch_select <= pwdata[`PDMC_CFG_WATCH];
            sub_divider_select <= pwdata[`PDMC_CFG_SUB_HI:`PDMC_CFG_SUB_LO];
         end
      end
   end

   //**********************************************
   // clock dividers
   //**********************************************
   // divider masks; subclock select 11 falls back to /8
   always @* begin
      case (medium_divider_select)
         2'h0: pmask = `PDMC_PM_16;
         2'h1: pmask = `PDMC_PM_32;
         2'h2: pmask = `PDMC_PM_64;
         default: pmask = `PDMC_PM_128;
      endcase
      case (sub_divider_select)
         2'h0: smask = `PDMC_SM_2;
         2'h1: smask = `PDMC_SM_4;
         default: smask = `PDMC_SM_8;
      endcase
   end

   assign sys_tick = ((presc & pmask) == pmask);
   assign sub_tick = watch_tick & ((sub_cnt & smask) == smask);

   // free-running prescalers; watch side keeps counting always
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc <= 7'h00;
         sub_cnt <= 3'h0;
      end else begin
         presc <= presc + 7'h01;
         if (watch_tick) begin
            sub_cnt <= sub_cnt + 3'h1;
         end
      end
   end

   //**********************************************
   // wake wait length
   //**********************************************
   // variant picks the middle three encodings
   always @* begin
      case (wake_wait_select)
         `PDMC_WS_8192: wait_len = WAIT_8192;
         `PDMC_WS_16384: wait_len = WAIT_16384;
         `PDMC_WS_V2: wait_len = OSC_VARIANT ? WAIT_32768 : WAIT_1024;
         `PDMC_WS_V3: wait_len = OSC_VARIANT ? WAIT_65536 : WAIT_2048;
         `PDMC_WS_V4: wait_len = OSC_VARIANT ? WAIT_131072 : WAIT_4096;
         `PDMC_WS_EXT: wait_len = `PDMC_ST_2;
         `PDMC_WS_8: wait_len = `PDMC_ST_8;
         default: wait_len = `PDMC_ST_16;
      endcase
   end

   //**********************************************
   // mode state machine
   //**********************************************
   // the wait is counted exactly; hardware never cuts it short,
   // which is the safe reading of early resume
   always @* begin
      next_mode = mode;
      next_wait = wait_cnt;
      case (mode)
         `PDMC_M_ACT_HI, `PDMC_M_ACT_MED: begin
            if (sleep_req) begin
               if (!deep_standby_select) begin
                  next_mode = (mode == `PDMC_M_ACT_HI) ?
                     `PDMC_M_SLP_HI : `PDMC_M_SLP_MED;
               end else begin
                  next_mode = watch_select ? `PDMC_M_WATCH :
                     `PDMC_M_STANDBY;
               end
            end else begin
               next_mode = medium_speed_sel ? `PDMC_M_ACT_MED :
                  `PDMC_M_ACT_HI;
            end
         end
         `PDMC_M_SUBACT: begin
            if (sleep_req) begin
               next_mode = deep_standby_select ? `PDMC_M_WATCH :
                  `PDMC_M_SUBSLP;
            end
         end
         `PDMC_M_SLP_HI: begin
            if (wake_irq) begin
               next_mode = `PDMC_M_ACT_HI;
            end
         end
         `PDMC_M_SLP_MED: begin
            if (wake_irq) begin
               next_mode = `PDMC_M_ACT_MED;
            end
         end
         `PDMC_M_SUBSLP: begin
            if (wake_irq) begin
               next_mode = `PDMC_M_SUBACT;
            end
         end
         `PDMC_M_WATCH: begin
            if (wake_irq) begin
               if (watch_exit_clock_select) begin
                  next_mode = `PDMC_M_SUBACT;
               end else begin
                  next_mode = `PDMC_M_WAKE;
                  next_wait = wait_len - 18'd1;
               end
            end
         end
         `PDMC_M_STANDBY: begin
            if (wake_irq) begin
               next_mode = `PDMC_M_WAKE;
               next_wait = wait_len - 18'd1;
            end
         end
         `PDMC_M_WAKE: begin
            if (wait_cnt == 18'd0) begin
               next_mode = medium_speed_sel ? `PDMC_M_ACT_MED :
                  `PDMC_M_ACT_HI;
            end else begin
               next_wait = wait_cnt - 18'd1;
            end
         end
         default: next_mode = `PDMC_M_ACT_HI;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= `PDMC_M_ACT_HI;
         wait_cnt <= 18'd0;
      end else begin
         mode <= next_mode;
         wait_cnt <= next_wait;
      end
   end

   //**********************************************
   // clock gating outputs
   //**********************************************
   // cpu and peripheral mask per mode
   always @* begin
      next_cpu_run = 1'b0;
      next_cpu_tick = 1'b0;
      mode_mask = {NMOD{1'b0}};
      mode_on_sub = 1'b0;
      case (mode)
         `PDMC_M_ACT_HI: begin
            next_cpu_run = 1'b1;
            next_cpu_tick = 1'b1;
            mode_mask = {NMOD{1'b1}};
         end
         `PDMC_M_ACT_MED: begin
            next_cpu_run = 1'b1;
            next_cpu_tick = sys_tick;
            mode_mask = {NMOD{1'b1}};
         end
         `PDMC_M_SUBACT: begin
            next_cpu_run = 1'b1;
            next_cpu_tick = sub_tick;
            mode_mask = {NMOD{1'b1}};
            mode_on_sub = 1'b1;
         end
         `PDMC_M_SLP_HI, `PDMC_M_SLP_MED: begin
            mode_mask = {NMOD{1'b1}};
         end
         `PDMC_M_SUBSLP: begin
            mode_mask = `PDMC_MASK_SUBSLP;
            mode_on_sub = 1'b1;
         end
         `PDMC_M_WATCH: begin
            mode_mask = `PDMC_MASK_WATCH;
            mode_on_sub = 1'b1;
         end
         default: begin
            mode_mask = {NMOD{1'b0}};
         end
      endcase
   end

   // per-module tick, gated by mode and by the halt register
   genvar gi;
   generate
      for (gi = 0; gi < NMOD; gi = gi + 1) begin : g_mod
         wire src = mode_on_sub ? sub_tick :
            ((mode == `PDMC_M_SLP_MED) ? sys_tick : 1'b1);
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               periph_tick[gi] <= 1'b0;
            end else begin
               periph_tick[gi] <= mode_mask[gi] & ~module_clock_halt[gi]
                  & src;
            end
         end
      end
   endgenerate

   // oscillator halted in standby, watch and the sub modes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_run <= 1'b1;
         cpu_tick <= 1'b0;
         osc_run <= 1'b1;
         mode_code <= `PDMC_M_ACT_HI;
      end else begin
         cpu_run <= next_cpu_run;
         cpu_tick <= next_cpu_tick;
         osc_run <= (mode != `PDMC_M_STANDBY) & (mode != `PDMC_M_WATCH)
            & ~mode_on_sub;
         mode_code <= mode;
      end
   end

endmodule
`default_nettype wire

/* test/pdmc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_defines.vh"
// ****************
// port checker
// ****************
module pdmc_monitor #(
   parameter NMOD = 8
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire sleep_req,
   input wire wake_irq,
   input wire watch_tick,
   input wire [3:0] mode_code,
   input wire cpu_run,
   input wire cpu_tick,
   input wire osc_run,
   input wire [NMOD-1:0] periph_tick
);
   default clocking dclk @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // entry and wake steps, seen through the lagging mode code
   sequence s_sleep_cmd;
      sleep_req && mode_code == `PDMC_M_ACT_HI;
   endsequence
   sequence s_wake_cmd;
      wake_irq && mode_code == `PDMC_M_STANDBY;
   endsequence
   sequence s_wait_min;
      (mode_code == `PDMC_M_WAKE) [*2];
   endsequence
   apb_answer_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   rsvd_bit_a: assert property (pready && !pwrite && !pslverr &&
      paddr == `PDMC_ADDR_CTRL_ONE |-> prdata[`PDMC_BIT_RSVD])
      else $error("reserved bit read zero");
   sleep_enter_a: assert property (s_sleep_cmd |-> ##[1:2]
      mode_code inside {4'h3, 4'h4, 4'h6, 4'h7})
      else $error("sleep request not taken");
   sleep_cpu_a: assert property (mode_code inside {4'h3, 4'h4} |->
      !cpu_run && !cpu_tick)
      else $error("cpu runs in sleep");
   subsleep_mask_a: assert property (mode_code == `PDMC_M_SUBSLP |->
      !cpu_run && (periph_tick & ~`PDMC_MASK_SUBSLP) == 0)
      else $error("wrong module clocked in subsleep");
   watch_mask_a: assert property (mode_code == `PDMC_M_WATCH |->
      !cpu_run && (periph_tick & ~`PDMC_MASK_WATCH) == 0)
      else $error("wrong module clocked in watch");
   standby_halt_a: assert property (mode_code == `PDMC_M_STANDBY |->
      !cpu_run && !osc_run && periph_tick == 0)
      else $error("clock alive in standby");
   wake_wait_a: assert property (s_wake_cmd |-> ##[1:2] s_wait_min)
      else $error("standby wake skipped wait");
   wake_hold_a: assert property (mode_code == `PDMC_M_WAKE |->
      !cpu_run && !cpu_tick && periph_tick == 0 && osc_run)
      else $error("released during wake wait");
endmodule
bind pdmc_top pdmc_monitor #(.NMOD(NMOD)) u_mon (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sleep_req(sleep_req), .wake_irq(wake_irq),
   .watch_tick(watch_tick), .mode_code(mode_code), .cpu_run(cpu_run),
   .cpu_tick(cpu_tick), .osc_run(osc_run), .periph_tick(periph_tick));
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// bench
// ****************
module tb_top;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, sleep_req = 1'h0, wake_irq = 1'h0;
   logic watch_tick = 1'h0, er;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, rd;
   logic [1:0] wcnt = 2'h0;
   logic [7:0] acc;
   logic [76:0] rows [0:5];
   wire [31:0] prdata;
   wire pready, pslverr, cpu_run, cpu_tick, osc_run;
   wire [3:0] mode_code;
   wire [7:0] periph_tick;
   integer err_count = 0, n_tests = 0, i, n;
   integer wexp [0:7];
   // short wake waits keep the run brief; fixed 2/8/16 stay real
   pdmc_top #(.WAIT_1024(18'd12), .WAIT_2048(18'd13), .WAIT_4096(18'd14),
      .WAIT_8192(18'd20), .WAIT_16384(18'd24)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_req(sleep_req), .wake_irq(wake_irq),
      .watch_tick(watch_tick), .mode_code(mode_code), .cpu_run(cpu_run),
      .cpu_tick(cpu_tick), .osc_run(osc_run), .periph_tick(periph_tick));
   always #10 pclk = ~pclk;
   // watch clock tick every fourth cycle
   always @(posedge pclk) begin
      wcnt <= wcnt + 2'h1;
      watch_tick <= (wcnt == 2'h3);
   end
   task report_and_stop;
      begin
         $display("errors %0d, checks %0d", err_count, n_tests);
         if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
         end else begin
            $display("*** FAIL ***");
         end
         $finish;
      end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task hang;
      begin
         err_count = err_count + 1;
         $display("ERROR %0t: wait ran out", $time);
         report_and_stop;
      end
   endtask
   // request held until pready is seen at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer k;
      begin
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'h1;
         k = 0;
         do begin
            @(posedge pclk);
            k = k + 1;
         end while (pready !== 1'h1 && k < 20);
         if (pready !== 1'h1) hang;
         rd = prdata;
         er = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
         // idle edge: no strobe is driven twice in one step
         @(posedge pclk);
      end
   endtask
   task pulse(input logic s);
      begin
         sleep_req <= s;
         wake_irq <= ~s;
         @(posedge pclk);
         sleep_req <= 1'h0;
         wake_irq <= 1'h0;
      end
   endtask
   task wait_mode(input logic [3:0] m);
      integer k;
      begin
         for (k = 0; k < 300 && mode_code !== m; k = k + 1) @(posedge pclk);
         if (k >= 300) hang;
         chk(mode_code, m);
      end
   endtask
   task count_ticks(input integer cyc, input integer exp);
      integer k;
      begin
         n = 0;
         for (k = 0; k < cyc; k = k + 1) begin
            @(posedge pclk);
            n = n + cpu_tick;
         end
         chk(n, exp);
      end
   endtask
   task do_reset;
      begin
         presetn <= 1'h0;
         repeat (16) @(posedge pclk);
         presetn <= 1'h1;
         @(posedge pclk);
         chk({cpu_run, mode_code}, 5'h10);
         apb(1'h0, 12'h000, 32'h0);
         chk(rd, 32'h07);
      end
   endtask
   // main sequence: register rows, then mode walks
   initial begin
      rows[0] = {12'h000, 32'hff, 32'hff, 1'h0};
      rows[1] = {12'h000, 32'h00, 32'h04, 1'h0};
      rows[2] = {12'h000, 32'h7b, 32'h7f, 1'h0};
      rows[3] = {12'h004, 32'h05, 32'h05, 1'h0};
      rows[4] = {12'h00c, 32'hff, 32'h00, 1'h0};
      rows[5] = {12'h010, 32'h01, 32'h00, 1'h1};
      wexp = '{20, 24, 12, 13, 14, 2, 8, 16};
      do_reset;
      for (i = 0; i < 6; i = i + 1) begin
         apb(1'h1, rows[i][76:65], rows[i][64:33]);
         chk(er, rows[i][0]);
         apb(1'h0, rows[i][76:65], 32'h0);
         chk(rd, rows[i][32:1]);
         chk(er, rows[i][0]);
      end
      acc = 8'h0;
      repeat (16) @(posedge pclk) acc = acc | periph_tick;
      chk(acc, 8'hfa);
      apb(1'h1, 12'h004, 32'h0);
      apb(1'h1, 12'h000, 32'h0);
      apb(1'h1, 12'h008, 32'h1);
      wait_mode(4'h1);
      count_ticks(128, 8);
      pulse(1'h1);
      wait_mode(4'h4);
      pulse(1'h0);
      wait_mode(4'h1);
      apb(1'h1, 12'h008, 32'h0);
      apb(1'h1, 12'h000, 32'h3);
      apb(1'h1, 12'h008, 32'h1);
      wait_mode(4'h1);
      count_ticks(128, 1);
      apb(1'h1, 12'h008, 32'h0);
      wait_mode(4'h0);
      pulse(1'h1);
      wait_mode(4'h3);
      pulse(1'h0);
      wait_mode(4'h0);
      for (i = 0; i < 8; i = i + 1) begin
         apb(1'h1, 12'h000, 32'h80 | (i << 4));
         pulse(1'h1);
         wait_mode(4'h7);
         chk({osc_run, cpu_run, periph_tick}, 32'h0);
         pulse(1'h0);
         wait_mode(4'h8);
         for (n = 1; n < 300 && mode_code === 4'h8; n = n + 1) @(posedge pclk);
         chk(n - 1, wexp[i]);
         wait_mode(4'h0);
      end
      apb(1'h1, 12'h008, 32'h2);
      apb(1'h1, 12'h000, 32'h88);
      pulse(1'h1);
      wait_mode(4'h6);
      pulse(1'h0);
      wait_mode(4'h2);
      count_ticks(64, 8);
      apb(1'h1, 12'h008, 32'ha);
      count_ticks(64, 2);
      apb(1'h1, 12'h000, 32'h0);
      pulse(1'h1);
      wait_mode(4'h5);
      pulse(1'h0);
      wait_mode(4'h2);
      apb(1'h1, 12'h000, 32'he0);
      pulse(1'h1);
      wait_mode(4'h6);
      pulse(1'h0);
      wait_mode(4'h8);
      wait_mode(4'h0);
      pulse(1'h1);
      wait_mode(4'h6);
      do_reset;
      report_and_stop;
   end
endmodule
`default_nettype wire
